// ### rtl/fweg_params.svh
// Constants for the flash write and erase gate
//
// Summary of operation
// - Control bits 7:2 read zero, ignore writes
// - Write enable steers data moves to flash
// - No flash programming while write enable clear
// - Both enables set: data move erases page
// - Erase ignores the data byte
// - Erase enable clear: never erase pages
// - One operation relocks, needing new keys
// - Wrong key sequence locks until reset
// - Flash access while locked and not busy locks until reset; a key write in the same cycle wins
// - Non-first-key write deliberately locks out
// - Key read returns lock state bits
// - States 00 locked, 01 first, 10 open
// - State 11 means locked until reset
`ifndef FWEG_PARAMS_SVH
`define FWEG_PARAMS_SVH
// ==========================================================
// Register map
`define FWEG_ADDR_CTRL   8'h8f
`define FWEG_ADDR_KEY    8'hb7
`define FWEG_CTRL_RESET  8'h00
`define FWEG_BIT_WE      0
`define FWEG_BIT_EE      1
// ==========================================================
// Key values
`define FWEG_KEY_FIRST   8'ha5
`define FWEG_KEY_SECOND  8'hf1
`endif

// ### rtl/fweg_pkg.sv
// Types for the flash write and erase gate
`default_nettype none
package fweg_pkg;
	typedef enum logic [1:0] {
		FWEG_LOCKED = 2'b00,
		FWEG_FIRST  = 2'b01,
		FWEG_OPEN   = 2'b10,
		FWEG_DEAD   = 2'b11
	} fweg_key_type;
endpackage
`default_nettype wire

// ### rtl/fweg_gate.sv
// Flash write and erase gate with key lock and control register
`timescale 1ns/1ps
`default_nettype none
`include "fweg_params.svh"
module fweg_gate
	import fweg_pkg::*;
(
	input  wire logic        i_mclk,
	input  wire logic        i_rst,
	input  wire logic [7:0]  i_sfr_addr,
	input  wire logic        i_sfr_wr,
	input  wire logic [7:0]  i_sfr_wdata,
	output logic      [7:0]  o_sfr_rdata,
	input  wire logic        i_xmove_wr,
	input  wire logic [15:0] i_xmove_addr,
	input  wire logic [7:0]  i_xmove_data,
	input  wire logic        i_flash_done,
	output logic             o_xram_wr,
	output logic             o_flash_prog,
	output logic             o_flash_erase,
	output logic      [15:0] o_flash_addr,
	output logic      [7:0]  o_flash_data,
	output logic      [1:0]  o_lock_state
);
	// ==========================================================
	// Decode
	function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
		hit = (a == r);
	endfunction

	logic         we_q;
	logic         ee_q;
	fweg_key_type key_q;
	fweg_key_type key_d;
	logic         busy_q;
	logic         flash_req;
	logic         ctrl_wr;
	logic         key_wr;

	assign ctrl_wr = i_sfr_wr && hit(i_sfr_addr, `FWEG_ADDR_CTRL);
	assign key_wr  = i_sfr_wr && hit(i_sfr_addr, `FWEG_ADDR_KEY);
	assign flash_req = i_xmove_wr && we_q && !busy_q;
	assign o_xram_wr = i_xmove_wr && !we_q;
	assign o_lock_state = key_q;

	// ==========================================================
	// Control register
	// Reset clears enables
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			we_q <= 1'b0;
			ee_q <= 1'b0;
		end else if (ctrl_wr) begin
			we_q <= i_sfr_wdata[`FWEG_BIT_WE];
			ee_q <= i_sfr_wdata[`FWEG_BIT_EE];
		end
	end

	// ==========================================================
	// Key state machine
	always_comb begin
		key_d = key_q;
		case (key_q)
			FWEG_LOCKED: begin
				if (key_wr)
					key_d = (i_sfr_wdata == `FWEG_KEY_FIRST) ?
						FWEG_FIRST : FWEG_DEAD;
				else if (flash_req)
					key_d = FWEG_DEAD;
			end
			FWEG_FIRST: begin
				if (key_wr)
					key_d = (i_sfr_wdata == `FWEG_KEY_SECOND) ?
						FWEG_OPEN : FWEG_DEAD;
				else if (flash_req)
					key_d = FWEG_DEAD;
			end
			FWEG_OPEN: begin
				if (key_wr)
					key_d = FWEG_DEAD;
				else if (flash_req)
					key_d = FWEG_LOCKED;
			end
			default: key_d = FWEG_DEAD;
		endcase
	end

	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst)
			key_q <= FWEG_LOCKED;
		else
			key_q <= key_d;
	end

	// ==========================================================
	// Flash operation launch
	// One operation in flight; moves before done are dropped, never queued
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			busy_q        <= 1'b0;
			o_flash_prog  <= 1'b0;
			o_flash_erase <= 1'b0;
			o_flash_addr  <= 16'h0000;
			o_flash_data  <= 8'h00;
		end else begin
			o_flash_prog  <= 1'b0;
			o_flash_erase <= 1'b0;
			if (flash_req && key_q == FWEG_OPEN && !key_wr) begin
				busy_q        <= 1'b1;
				o_flash_addr  <= i_xmove_addr;
				o_flash_erase <= ee_q;
				o_flash_prog  <= !ee_q;
				o_flash_data  <= ee_q ? 8'h00 : i_xmove_data;
			end else if (i_flash_done) begin
				busy_q <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Readback
	// Key read returns state
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst)
			o_sfr_rdata <= 8'h00;
		else if (hit(i_sfr_addr, `FWEG_ADDR_CTRL))
			o_sfr_rdata <= {6'h00, ee_q, we_q};
		else if (hit(i_sfr_addr, `FWEG_ADDR_KEY))
			o_sfr_rdata <= {6'h00, key_q};
		else
			o_sfr_rdata <= 8'h00;
	end

	// ==========================================================
	// Checks
	// All checks share the one clock and stop during reset
	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (i_rst);

	a_first_key: assert property (
		(key_q == FWEG_LOCKED && key_wr &&
		 i_sfr_wdata == `FWEG_KEY_FIRST) |=> key_q == FWEG_FIRST)
		else $error("first key not accepted");
	a_second_key: assert property (
		(key_q == FWEG_FIRST && key_wr &&
		 i_sfr_wdata == `FWEG_KEY_SECOND) |=> key_q == FWEG_OPEN)
		else $error("second key not accepted");
	a_op_relocks: assert property (
		(key_q == FWEG_OPEN && flash_req && !key_wr) |=>
		key_q == FWEG_LOCKED)
		else $error("open state not relocked after operation");
	a_busy_drop: assert property (
		(busy_q && i_xmove_wr && !key_wr) |=>
		!o_flash_prog && !o_flash_erase && key_q == $past(key_q))
		else $error("move during busy was not dropped");
	a_locked_access: assert property (
		(key_q == FWEG_LOCKED && flash_req && !key_wr) |=>
		key_q == FWEG_DEAD)
		else $error("locked access did not lock out");
	a_bad_key: assert property (
		(key_q == FWEG_FIRST && key_wr &&
		 i_sfr_wdata != `FWEG_KEY_SECOND) |=> key_q == FWEG_DEAD)
		else $error("bad second key not locked out");
	a_deliberate: assert property (
		(key_q == FWEG_LOCKED && key_wr &&
		 i_sfr_wdata != `FWEG_KEY_FIRST) |=> key_q == FWEG_DEAD)
		else $error("deliberate lock ignored");
	a_dead_sticks: assert property (
		key_q == FWEG_DEAD |=> key_q == FWEG_DEAD)
		else $error("lockout released without reset");
	a_dead_no_op: assert property (
		key_q == FWEG_DEAD |=> !o_flash_prog && !o_flash_erase)
		else $error("flash op while locked out");
	a_prog_launch: assert property (
		(flash_req && key_q == FWEG_OPEN && !key_wr && !ee_q) |=>
		o_flash_prog && !o_flash_erase &&
		o_flash_addr == $past(i_xmove_addr) &&
		o_flash_data == $past(i_xmove_data))
		else $error("byte program not launched");
	a_erase_launch: assert property (
		(flash_req && key_q == FWEG_OPEN && !key_wr && ee_q) |=>
		o_flash_erase && !o_flash_prog &&
		o_flash_addr == $past(i_xmove_addr))
		else $error("page erase not launched");
	a_erase_data: assert property (
		o_flash_erase |-> o_flash_data == 8'h00)
		else $error("erase carried a data byte");
	a_erase_gate: assert property (
		o_flash_erase |-> $past(ee_q) && $past(key_q) == FWEG_OPEN)
		else $error("erase without erase enable");
	a_prog_gate: assert property (
		(o_flash_prog || o_flash_erase) |-> $past(we_q))
		else $error("flash op without write enable");
	a_ctrl_read: assert property (
		hit(i_sfr_addr, `FWEG_ADDR_CTRL) |=>
		o_sfr_rdata == {6'h00, $past(ee_q), $past(we_q)})
		else $error("control readback wrong");
	a_key_read: assert property (
		hit(i_sfr_addr, `FWEG_ADDR_KEY) |=>
		o_sfr_rdata == {6'h00, $past(key_q)})
		else $error("key read not lock state");
	c_unlock: cover property (key_q == FWEG_FIRST ##1 key_q == FWEG_OPEN);
	c_prog: cover property (o_flash_prog);
	c_erase: cover property (o_flash_erase);
	c_dead: cover property (key_q == FWEG_DEAD);
	c_busy_drop: cover property (busy_q && i_xmove_wr);
endmodule
`default_nettype wire

// ### dv/fweg_flash_model.sv
// Flash array stand-in that reports the end of each operation
`timescale 1ns/1ps
`default_nettype none
module fweg_flash_model #(
	parameter int DELAY = 4
) (
	input  wire logic i_mclk,
	input  wire logic i_rst,
	input  wire logic i_start,
	output logic      o_done
);
	int cnt_q;
	// ==========================================================
	// Done pulse
	// Slow enough that a busy gate is really exercised
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			cnt_q  <= 0;
			o_done <= 1'b0;
		end else begin
			o_done <= (cnt_q == 1);
			if (i_start) begin
				cnt_q <= DELAY;
			end else if (cnt_q != 0) begin
				cnt_q <= cnt_q - 1;
			end
		end
	end
endmodule
`default_nettype wire

// ### dv/test_fweg_gate.sv
// Bench for the flash write and erase gate
`timescale 1ns/1ps
`default_nettype none
`include "fweg_params.svh"
module test_fweg_gate;
	logic        i_mclk = 1'b0;
	logic        i_rst, sw, xw, done, xram, prog, erase;
	logic [7:0]  sa, sd, xd, rdata, fdat, fd;
	logic [15:0] xa, fadr, fa;
	logic [1:0]  lock;
	int          failures, n_tests, n_prog, n_er, cyc;
	always #20 i_mclk = ~i_mclk;
	fweg_gate u_fweg_gate (.i_mclk(i_mclk), .i_rst(i_rst),
		.i_sfr_addr(sa), .i_sfr_wr(sw), .i_sfr_wdata(sd),
		.o_sfr_rdata(rdata), .i_xmove_wr(xw), .i_xmove_addr(xa),
		.i_xmove_data(xd), .i_flash_done(done), .o_xram_wr(xram),
		.o_flash_prog(prog), .o_flash_erase(erase),
		.o_flash_addr(fadr), .o_flash_data(fdat), .o_lock_state(lock));
	fweg_flash_model u_fweg_flash_model (.i_mclk(i_mclk), .i_rst(i_rst),
		.i_start(prog | erase), .o_done(done));
	// ==========================================================
	// Pulse capture and hang guard
	always @(negedge i_mclk) begin
		cyc++;
		if (prog) n_prog++;
		if (erase) n_er++;
		if (prog || erase) begin
			fa = fadr;
			fd = fdat;
		end
		if (cyc == 3000) begin
			failures++;
			conclude();
		end
	end
	// ==========================================================
	// Tasks
	task automatic chk(input string nm, input logic [15:0] e,
		input logic [15:0] g);
		n_tests++;
		if (g !== e) begin
			failures++;
			$display("CHECK FAILED %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge i_mclk);
		sa = a;
		sd = d;
		sw = 1'b1;
		@(negedge i_mclk);
		sw = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(negedge i_mclk);
		sa = a;
		@(negedge i_mclk);
		chk("rdata", {8'h00, e}, {8'h00, rdata});
	endtask
	// A zero wait leaves the flash busy for the next move
	task automatic mv(input logic [15:0] a, input logic [7:0] d,
		input logic ex, input int w);
		@(negedge i_mclk);
		xa = a;
		xd = d;
		xw = 1'b1;
		#1 chk("xram_wr", {15'h0, ex}, {15'h0, xram});
		@(negedge i_mclk);
		xw = 1'b0;
		repeat (w) @(negedge i_mclk);
	endtask
	task automatic unlock;
		wr(`FWEG_ADDR_KEY, `FWEG_KEY_FIRST);
		rd(`FWEG_ADDR_KEY, 8'h01);
		wr(`FWEG_ADDR_KEY, `FWEG_KEY_SECOND);
		rd(`FWEG_ADDR_KEY, 8'h02);
		chk("lock", 16'h0002, {14'h0, lock});
	endtask
	task automatic rst_pulse;
		@(negedge i_mclk);
		i_rst = 1'b1;
		@(negedge i_mclk);
		i_rst = 1'b0;
	endtask
	task automatic conclude;
		$display("checks %0d failures %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// ==========================================================
	// Sequence
	initial begin
		{sw, xw, sa, sd, xa, xd} = '0;
		i_rst = 1'b1;
		repeat (12) @(posedge i_mclk);
		@(negedge i_mclk);
		i_rst = 1'b0;
		rd(`FWEG_ADDR_CTRL, `FWEG_CTRL_RESET);
		rd(`FWEG_ADDR_KEY, 8'h00);
		wr(`FWEG_ADDR_CTRL, 8'hfc);
		rd(`FWEG_ADDR_CTRL, 8'h00);
		mv(16'h1234, 8'h11, 1'b1, 8);
		chk("prog", 16'd0, n_prog[15:0]);
		unlock();
		wr(`FWEG_ADDR_CTRL, 8'h03);
		rd(`FWEG_ADDR_CTRL, 8'h03);
		mv(16'h0456, 8'h5a, 1'b0, 8);
		chk("erase", 16'd1, n_er[15:0]);
		chk("fdata", 16'h0, {8'h00, fd});
		chk("faddr", 16'h0456, fa);
		rd(`FWEG_ADDR_KEY, 8'h00);
		unlock();
		wr(`FWEG_ADDR_CTRL, 8'h01);
		mv(16'h0456, 8'h3c, 1'b0, 0);
		mv(16'h0458, 8'h99, 1'b0, 8);
		rd(`FWEG_ADDR_KEY, 8'h00);
		chk("prog", 16'd1, n_prog[15:0]);
		chk("erase", 16'd1, n_er[15:0]);
		chk("fdata", 16'h3c, {8'h00, fd});
		mv(16'h0457, 8'h77, 1'b0, 8);
		rd(`FWEG_ADDR_KEY, 8'h03);
		chk("lock", 16'h0003, {14'h0, lock});
		chk("prog", 16'd1, n_prog[15:0]);
		rst_pulse();
		rd(`FWEG_ADDR_CTRL, 8'h00);
		chk("lock", 16'h0000, {14'h0, lock});
		wr(`FWEG_ADDR_KEY, 8'h12);
		rd(`FWEG_ADDR_KEY, 8'h03);
		rst_pulse();
		wr(`FWEG_ADDR_KEY, `FWEG_KEY_FIRST);
		wr(`FWEG_ADDR_KEY, `FWEG_KEY_FIRST);
		rd(`FWEG_ADDR_KEY, 8'h03);
		conclude();
	end
endmodule
`default_nettype wire
